// ---- rtl/drc_debug_regs.sv ----
// Purpose: debug register ownership, compare registers, debug counters
// Assumes: software and debug port each offer one access per cycle
// Notes:   the debug port wins when both write in the same cycle
`include "drc_defs.svh"

// Overview of operation
// RL1: external mode blocks unowned software register writes
// RL2: status register always belongs to software
// RL3: blocked software writes change nothing, no error
// RL4: mode bit and ownership register read reliably
// RL5: debug port may write every register field
// RL6: even instruction compares mask odd ones; the code uses each odd register as the mask of its even compare
// RL7: ignore low address bits per encoding
// RL8: second data compare masks the first
// RL9: two 64-bit value registers qualify data hits
// RL10: msb byte matches memory offset zero
// RL11: only enabled active lanes are compared
// RL12: only first transfer of split access matches
// RL13: value registers full width, kept over reset
// RL14: two 16-bit counters, optionally one 32-bit
// RL15: counters decrement on any enabled event
// RL16: event only on one to zero, then frozen
// RL17: zero-loaded counter never counts or signals
// RL18: software synchronises after control writes
// RL19: compare and count ignore status enables
// RL20: primary control at 308, resets to zero
// RL21: status records events in internal mode
// RL22: mode bit writable only from debug port
module drc_debug_regs (
  input  wire logic                 i_mclk,
  input  wire logic                 i_rst_b,
  input  wire logic                 i_sw_wr,
  input  wire logic                 i_sw_rd,
  input  wire drc_pkg::drc_spr_t    i_sw_spr,
  input  wire drc_pkg::drc_dword_t  i_sw_wdata,
  output drc_pkg::drc_dword_t       o_sw_rdata,
  input  wire logic                 i_dp_wr,
  input  wire logic                 i_dp_rd,
  input  wire drc_pkg::drc_spr_t    i_dp_spr,
  input  wire drc_pkg::drc_dword_t  i_dp_wdata,
  output drc_pkg::drc_dword_t       o_dp_rdata,
  input  wire logic                 i_if_vld,
  input  wire drc_pkg::drc_word_t   i_if_addr,
  input  wire logic                 i_if_vle,
  input  wire logic                 i_da_vld,
  input  wire logic                 i_da_second,
  input  wire logic                 i_da_store,
  input  wire drc_pkg::drc_word_t   i_da_addr,
  input  wire logic [7:0]           i_da_lanes,
  input  wire drc_pkg::drc_dword_t  i_da_data,
  output logic [7:0]                o_iac_hit,
  output logic [1:0]                o_dac_hit,
  output logic [1:0]                o_cnt_event,
  output logic                      o_ext_debug_mode
);
  drc_pkg::drc_word_t  ctrl_r, stat_r, cfg_r;
  logic [15:0]         own_r;
  drc_pkg::drc_word_t  iac_r [8];
  drc_pkg::drc_word_t  dac_r [2];
  drc_pkg::drc_dword_t dvc_r [2];
  drc_pkg::drc_cnt_t   cnt_up, cnt_lo;
  logic                external_debug_mode_bit, idm, sw_ok, w_sw, wr;
  drc_pkg::drc_spr_t   wa;
  drc_pkg::drc_dword_t wd;
  logic [7:0]          iac_nxt;
  logic [1:0]          dac_nxt, dvc_ok;
  logic [31:0]         ign, evt, stat_set;
  logic                ev_up, ev_lo, dec_up, dec_lo, ccat, ld_cnt;
  logic [1:0]          cnt_ev_nxt;

  assign external_debug_mode_bit              = ctrl_r[`DRC_CTRL_EDM];
  assign idm              = ctrl_r[`DRC_CTRL_IDM];
  assign o_ext_debug_mode = external_debug_mode_bit;
  assign ccat             = cfg_r[`DRC_CFG_CCAT];

  function automatic int res_of(input drc_pkg::drc_spr_t a);
    if (a == `DRC_SPR_CTRL) begin
      return `DRC_OWN_CTRL;
    end else if (a[9:3] == 7'(`DRC_SPR_IAC0 >> 3)) begin
      return `DRC_OWN_IAC0 + int'(a[2:0]);
    end else if (a[9:1] == 9'(`DRC_SPR_DAC0 >> 1)) begin
      return `DRC_OWN_DAC0 + int'(a[0]);
    end else if (a[9:1] == 9'(`DRC_SPR_DATA_VALUE_COMPARE_FIRST >> 1)) begin
      return `DRC_OWN_DVC0 + int'(a[0]);
    end else if (a == `DRC_SPR_CNT) begin
      return `DRC_OWN_CNT;
    end else begin
      return `DRC_OWN_CFG;
    end
  endfunction : res_of

  // status is always software's; ownership reg only from the debug port
  always_comb begin
    sw_ok = !external_debug_mode_bit || own_r[4'(res_of(i_sw_spr))];    // [RL1]
    if (i_sw_spr == `DRC_SPR_STAT) begin
      sw_ok = 1'b1;                                  // [RL2]
    end else if (i_sw_spr == `DRC_SPR_OWN) begin
      sw_ok = 1'b0;
    end
  end

  // a refused software write just vanishes, no fault raised
  assign w_sw = i_sw_wr && !i_dp_wr && sw_ok;        // [RL3]
  assign wr   = i_dp_wr || w_sw;                     // [RL5]
  assign wa   = i_dp_wr ? i_dp_spr : i_sw_spr;
  assign wd   = i_dp_wr ? i_dp_wdata : i_sw_wdata;

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl_r <= `DRC_CTRL_RST;                       // [RL20]
    end else if (wr && wa == `DRC_SPR_CTRL) begin
      ctrl_r <= wd[31:0];
      if (!i_dp_wr) begin
        ctrl_r[`DRC_CTRL_EDM] <= external_debug_mode_bit;                // [RL22]
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      own_r <= 16'h0000;
    end else if (i_dp_wr && i_dp_spr == `DRC_SPR_OWN) begin
      own_r <= i_dp_wdata[15:0];
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cfg_r <= 32'h0000_0000;
    end else if (wr && wa == `DRC_SPR_CFG) begin
      cfg_r <= wd[31:0];
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int i = 0; i < 8; i++) begin
        iac_r[i] <= 32'h0000_0000;
      end
      dac_r[0] <= 32'h0000_0000;
      dac_r[1] <= 32'h0000_0000;
    end else if (wr) begin
      for (int i = 0; i < 8; i++) begin
        if (wa == `DRC_SPR_IAC0 + 10'(i)) begin
          iac_r[i] <= wd[31:0];
        end
      end
      for (int i = 0; i < 2; i++) begin
        if (wa == `DRC_SPR_DAC0 + 10'(i)) begin
          dac_r[i] <= wd[31:0];
        end
      end
    end
  end

  // value registers keep their contents across reset
  always_ff @(posedge i_mclk) begin
    if (wr && wa == `DRC_SPR_DATA_VALUE_COMPARE_FIRST) begin
      dvc_r[0] <= wd;                                // [RL13]
    end
    if (wr && wa == `DRC_SPR_DATA_VALUE_COMPARE_SECOND) begin
      dvc_r[1] <= wd;                                // [RL13]
    end
  end

  // compares run whatever the status enables say
  always_comb begin
    ign = i_if_vle ? 32'hffff_fffe : 32'hffff_fffc;  // [RL7]
    for (int p = 0; p < 4; p++) begin
      if (cfg_r[p]) begin
        iac_nxt[2*p]   = i_if_vld && ((i_if_addr ^ iac_r[2*p]) // [RL6]
                         & ~iac_r[2*p+1] & ign) == '0;
        iac_nxt[2*p+1] = 1'b0;
      end else begin
        iac_nxt[2*p]   = i_if_vld &&
                         ((i_if_addr ^ iac_r[2*p]) & ign) == '0;
        iac_nxt[2*p+1] = i_if_vld &&
                         ((i_if_addr ^ iac_r[2*p+1]) & ign) == '0;
      end
    end
  end

  // lane k carries memory offset k, which is byte k from the msb
  always_comb begin
    for (int d = 0; d < 2; d++) begin
      dvc_ok[d] = 1'b1;
      for (int k = 0; k < 8; k++) begin
        if (cfg_r[`DRC_CFG_BE0+8*d+k] && i_da_lanes[k] &&   // [RL11]
            i_da_data[63-8*k -: 8] != dvc_r[d][63-8*k -: 8]) begin // [RL10]
          dvc_ok[d] = 1'b0;
        end
      end
      if (!cfg_r[`DRC_CFG_DVE0+d]) begin
        dvc_ok[d] = 1'b1;
      end
    end
    if (cfg_r[`DRC_CFG_DABM]) begin
      dac_nxt[0] = ((i_da_addr ^ dac_r[0]) & ~dac_r[1]) == '0; // [RL8]
      dac_nxt[1] = 1'b0;
    end else begin
      dac_nxt[0] = i_da_addr == dac_r[0];
      dac_nxt[1] = i_da_addr == dac_r[1];
    end
    dac_nxt = dac_nxt & dvc_ok & {2{i_da_vld && !i_da_second}}; // [RL9] [RL12]
  end

  // counter sources: bit 0 instruction hit, bit 1 data hit
  assign ev_up = (cfg_r[`DRC_CFG_CEV] && |iac_nxt) ||
                 (cfg_r[`DRC_CFG_CEV+1] && |dac_nxt);          // [RL15]
  assign ev_lo = (cfg_r[`DRC_CFG_CEV+2] && |iac_nxt) ||
                 (cfg_r[`DRC_CFG_CEV+3] && |dac_nxt);          // [RL15]
  assign ld_cnt = wr && wa == `DRC_SPR_CNT;
  // chained: the lower half borrows from the upper half
  assign dec_lo = !ld_cnt && ev_lo &&
                  (cnt_lo != '0 || (ccat && cnt_up != '0));    // [RL17]
  assign dec_up = !ld_cnt && (ccat ? (dec_lo && cnt_lo == '0)
                                   : (ev_up && cnt_up != '0)); // [RL14]

  always_comb begin
    if (ccat) begin
      cnt_ev_nxt = {dec_lo && cnt_lo == 16'h0001 && cnt_up == '0, 1'b0};
    end else begin
      cnt_ev_nxt = {dec_up && cnt_up == 16'h0001,
                    dec_lo && cnt_lo == 16'h0001};             // [RL16]
    end
  end

  drc_down_cnt #(.W(16)) u_cnt_up (
    .i_mclk   (i_mclk),
    .i_load   (ld_cnt),
    .i_ld_val (wd[31:16]),
    .i_dec    (dec_up),
    .i_wrap   (1'b0),
    .o_val    (cnt_up)
  );

  drc_down_cnt #(.W(16)) u_cnt_lo (
    .i_mclk   (i_mclk),
    .i_load   (ld_cnt),
    .i_ld_val (wd[15:0]),
    .i_dec    (dec_lo),
    .i_wrap   (ccat),
    .o_val    (cnt_lo)
  );

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_iac_hit   <= 8'h00;
      o_dac_hit   <= 2'h0;
      o_cnt_event <= 2'h0;
    end else begin
      o_iac_hit   <= iac_nxt;                        // [RL19]
      o_dac_hit   <= dac_nxt;
      o_cnt_event <= cnt_ev_nxt;
    end
  end

  always_comb begin
    evt = '0;
    evt[`DRC_EV_INSTR_ADDR_CMP_FIRST -: 4]  = iac_nxt[3:0];
    evt[`DRC_EV_INSTR_ADDR_CMP_FIFTH -: 4]  = iac_nxt[7:4];
    evt[`DRC_EV_DATA_ADDR_CMP_FIRST +: 2]  = {!i_da_store, i_da_store} & {2{dac_nxt[0]}};
    evt[`DRC_EV_DATA_ADDR_CMP_SECOND +: 2]  = {!i_da_store, i_da_store} & {2{dac_nxt[1]}};
    evt[`DRC_EV_UPPER_EVENT_COUNTER]       = cnt_ev_nxt[1];
    evt[`DRC_EV_LOWER_EVENT_COUNTER]       = cnt_ev_nxt[0];
    stat_set = evt & ctrl_r & {32{idm}};             // [RL21]
  end

  // write-one-to-clear; a new event in the same cycle wins
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      stat_r <= 32'h0000_0000;
    end else if (wr && wa == `DRC_SPR_STAT) begin
      stat_r <= (stat_r & ~wd[31:0]) | stat_set;     // [RL2]
    end else begin
      stat_r <= stat_r | stat_set;
    end
  end

  function automatic drc_pkg::drc_dword_t rd_mux(input drc_pkg::drc_spr_t a);
    if (a == `DRC_SPR_CTRL) begin
      return {32'h0, ctrl_r};
    end else if (a == `DRC_SPR_OWN) begin
      return {48'h0, own_r};                         // [RL4]
    end else if (a == `DRC_SPR_STAT) begin
      return {32'h0, stat_r};
    end else if (a == `DRC_SPR_CFG) begin
      return {32'h0, cfg_r};
    end else if (a[9:3] == 7'(`DRC_SPR_IAC0 >> 3)) begin
      return {32'h0, iac_r[a[2:0]]};
    end else if (a[9:1] == 9'(`DRC_SPR_DAC0 >> 1)) begin
      return {32'h0, dac_r[a[0]]};
    end else if (a[9:1] == 9'(`DRC_SPR_DATA_VALUE_COMPARE_FIRST >> 1)) begin
      return dvc_r[a[0]];                            // [RL13]
    end else if (a == `DRC_SPR_CNT) begin
      return {32'h0, cnt_up, cnt_lo};
    end else begin
      return 64'h0;
    end
  endfunction : rd_mux

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_sw_rdata <= 64'h0;
      o_dp_rdata <= 64'h0;
    end else begin
      if (i_sw_rd) begin
        o_sw_rdata <= rd_mux(i_sw_spr);
      end
      if (i_dp_rd) begin
        o_dp_rdata <= rd_mux(i_dp_spr);              // [RL5]
      end
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);

  sequence s_blocked_iac_wr;
    i_sw_wr && !i_dp_wr && external_debug_mode_bit && !own_r[`DRC_OWN_IAC0] &&
    i_sw_spr == `DRC_SPR_IAC0;
  endsequence
  property p_blocked_wr;
    s_blocked_iac_wr |=> $stable(iac_r[0]);
  endproperty
  a_blocked_wr: assert property (p_blocked_wr) // [RL1]
    else $error("unowned software write changed a compare register");

  property p_stat_clear;
    (i_sw_wr && !i_dp_wr && i_sw_spr == `DRC_SPR_STAT &&
     i_sw_wdata[31:0] == 32'hffff_ffff && stat_set == '0) |=> stat_r == '0;
  endproperty
  a_stat_clear: assert property (p_stat_clear) // [RL2]
    else $error("software could not clear the status register");

  property p_edm_sw;
    !i_dp_wr |=> $stable(external_debug_mode_bit);
  endproperty
  a_edm_sw: assert property (p_edm_sw) // [RL22]
    else $error("external mode bit changed without the debug port");

  sequence s_dp_iac_wr;
    i_dp_wr && i_dp_spr == `DRC_SPR_IAC0;
  endsequence
  property p_dp_full;
    s_dp_iac_wr |=> iac_r[0] == $past(i_dp_wdata[31:0]);
  endproperty
  a_dp_full: assert property (p_dp_full) // [RL5]
    else $error("debug port write did not land");

  property p_frozen;
    (cnt_up == '0 && !ld_cnt) |=> cnt_up == '0;
  endproperty
  a_frozen: assert property (p_frozen) // [RL16]
    else $error("zero counter moved");

  property p_cnt_evt;
    o_cnt_event[0] |-> $past(cnt_lo) == 16'h0001 && cnt_lo == '0;
  endproperty
  a_cnt_evt: assert property (p_cnt_evt) // [RL16]
    else $error("counter event without one to zero step");

  property p_second;
    i_da_second |=> o_dac_hit == 2'h0;
  endproperty
  a_second: assert property (p_second) // [RL12]
    else $error("second transfer produced a data hit");

  property p_vle_bit;
    (i_if_vld && i_if_vle && !cfg_r[0] &&
     (i_if_addr | 32'h1) == (iac_r[0] | 32'h1)) |=> o_iac_hit[0];
  endproperty
  a_vle_bit: assert property (p_vle_bit) // [RL7]
    else $error("low address bit not ignored on variable-length page");

  property p_no_idm;
    (!idm && !(wr && wa == `DRC_SPR_STAT)) |=> $stable(stat_r);
  endproperty
  a_no_idm: assert property (p_no_idm) // [RL21]
    else $error("status changed outside internal mode");
endmodule : drc_debug_regs

// ---- common/drc_defs.svh ----
// Purpose: offsets, field positions and reset values of the debug block
// Assumes: special-register numbers are 10 bits wide
// Notes:   bit positions are given lsb-first (bit 31 is the msb)
`ifndef DRC_DEFS_SVH
`define DRC_DEFS_SVH
`define DRC_SPR_CTRL   10'h134
`define DRC_SPR_DATA_VALUE_COMPARE_FIRST   10'h13e
`define DRC_SPR_DATA_VALUE_COMPARE_SECOND   10'h13f
`define DRC_SPR_CNT    10'h232
`define DRC_SPR_STAT   10'h130
`define DRC_SPR_OWN    10'h131
`define DRC_SPR_CFG    10'h132
`define DRC_SPR_IAC0   10'h140
`define DRC_SPR_DAC0   10'h148
`define DRC_CTRL_RST   32'h0000_0000
`define DRC_CTRL_EDM   31
`define DRC_CTRL_IDM   30
`define DRC_EV_INSTR_ADDR_CMP_FIRST    23
`define DRC_EV_INSTR_ADDR_CMP_FIFTH    14
`define DRC_EV_DATA_ADDR_CMP_FIRST    18
`define DRC_EV_DATA_ADDR_CMP_SECOND    16
`define DRC_EV_UPPER_EVENT_COUNTER    8
`define DRC_EV_LOWER_EVENT_COUNTER    7
`define DRC_OWN_CTRL   0
`define DRC_OWN_IAC0   1
`define DRC_OWN_DAC0   9
`define DRC_OWN_DVC0   11
`define DRC_OWN_CNT    13
`define DRC_OWN_CFG    14
`define DRC_CFG_DABM   4
`define DRC_CFG_DVE0   5
`define DRC_CFG_CCAT   7
`define DRC_CFG_BE0    8
`define DRC_CFG_CEV    24
`endif

// ---- common/drc_pkg.sv ----
// Purpose: shared types of the debug register block
// Assumes: nothing
// Notes:   constants live in drc_defs.svh
package drc_pkg;
  typedef logic [9:0]  drc_spr_t;
  typedef logic [31:0] drc_word_t;
  typedef logic [63:0] drc_dword_t;
  typedef logic [15:0] drc_cnt_t;
endpackage : drc_pkg

// ---- rtl/drc_down_cnt.sv ----
// Purpose: one 16-bit debug down counter
// Assumes: caller gates i_dec; value is kept over reset on purpose
// Notes:   a zero counter stays frozen unless i_wrap lets it borrow
module drc_down_cnt #(
  parameter int W = 16
) (
  input  wire logic         i_mclk,
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_ld_val,
  input  wire logic         i_dec,
  input  wire logic         i_wrap,
  output logic      [W-1:0] o_val
);
  // no reset: contents survive processor reset
  always_ff @(posedge i_mclk) begin
    if (i_load) begin
      o_val <= i_ld_val;
    end else if (i_dec && o_val != '0) begin
      o_val <= o_val - W'(1);
    end else if (i_dec && i_wrap) begin
      o_val <= '1;
    end
  end
endmodule : drc_down_cnt

// ---- verif/drc_dbg_model.sv ----
// Purpose: debugger model doing read-modify-write on the debug port
// Assumes: read data is valid one cycle after the read edge
// Notes:   idle address and data lines toggle so stale values never match
module drc_dbg_model (
  input  wire logic                i_mclk,
  input  wire logic                i_go,
  input  wire drc_pkg::drc_spr_t   i_spr,
  input  wire drc_pkg::drc_dword_t i_mask,
  input  wire drc_pkg::drc_dword_t i_val,
  input  wire drc_pkg::drc_dword_t i_rdata,
  output logic                     o_dp_wr,
  output logic                     o_dp_rd,
  output drc_pkg::drc_spr_t        o_dp_spr,
  output drc_pkg::drc_dword_t      o_dp_wdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] st_r;
  initial begin
    st_r = 2'h0;
    o_dp_wr = 1'b0;
    o_dp_rd = 1'b0;
    o_dp_spr = 10'h0;
    o_dp_wdata = 64'h0;
  end
  always @(posedge i_mclk) begin
    o_dp_rd <= 1'b0;
    o_dp_wr <= 1'b0;
    case (st_r)
      2'h0: begin
        if (i_go) begin
          o_dp_rd  <= 1'b1;
          o_dp_spr <= i_spr;
          st_r     <= 2'h1;
        end else begin
          o_dp_spr   <= ~o_dp_spr;
          o_dp_wdata <= ~o_dp_wdata;
        end
      end
      2'h1: st_r <= 2'h2;
      2'h2: begin
        // only masked bits change, software settings survive
        o_dp_wr    <= 1'b1;
        o_dp_wdata <= (i_rdata & ~i_mask) | (i_val & i_mask);
        st_r       <= 2'h3;
      end
      default: st_r <= 2'h0;
    endcase
  end
endmodule : drc_dbg_model

// ---- verif/test_drc_debug_regs.sv ----
// Purpose: self-checking bench of the debug register block
// Assumes: compare hits do not depend on the event enables
// Notes:   expectations are queued with the cycle they fall due
`include "drc_defs.svh"
module test_drc_debug_regs;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {int kind; int due; logic [63:0] exp;} drc_note_t;
  logic                i_mclk = 1'b0;
  logic                i_rst_b = 1'b0;
  logic                i_sw_wr = 1'b0;
  logic                i_sw_rd = 1'b0;
  drc_pkg::drc_spr_t   i_sw_spr = 10'h0;
  drc_pkg::drc_dword_t i_sw_wdata = 64'h0;
  logic                i_if_vld = 1'b0;
  drc_pkg::drc_word_t  i_if_addr = 32'h0;
  logic                i_if_vle = 1'b0;
  logic                i_da_vld = 1'b0;
  logic                i_da_second = 1'b0;
  logic                i_da_store = 1'b0;
  drc_pkg::drc_word_t  i_da_addr = 32'h0;
  logic [7:0]          i_da_lanes = 8'h0;
  drc_pkg::drc_dword_t i_da_data = 64'h0;
  logic                go = 1'b0;
  drc_pkg::drc_spr_t   go_spr = 10'h0;
  drc_pkg::drc_dword_t go_mask = 64'h0;
  drc_pkg::drc_dword_t go_val = 64'h0;
  logic                dp_wr, dp_rd, ext_mode;
  drc_pkg::drc_spr_t   dp_spr;
  drc_pkg::drc_dword_t dp_wdata, sw_rdata, dp_rdata, r64;
  logic [7:0]          iac_hit;
  logic [1:0]          dac_hit, cnt_event;
  int                  fails = 0;
  int                  comparisons = 0;
  int                  cyc_n = 0;
  int                  seed = 32'he3c6;
  drc_note_t           q[$];
  drc_note_t           n;

  drc_debug_regs drc_debug_regs_i (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
    .i_sw_wr(i_sw_wr), .i_sw_rd(i_sw_rd), .i_sw_spr(i_sw_spr),
    .i_sw_wdata(i_sw_wdata), .o_sw_rdata(sw_rdata), .i_dp_wr(dp_wr),
    .i_dp_rd(dp_rd), .i_dp_spr(dp_spr), .i_dp_wdata(dp_wdata),
    .o_dp_rdata(dp_rdata), .i_if_vld(i_if_vld), .i_if_addr(i_if_addr),
    .i_if_vle(i_if_vle), .i_da_vld(i_da_vld), .i_da_second(i_da_second),
    .i_da_store(i_da_store), .i_da_addr(i_da_addr),
    .i_da_lanes(i_da_lanes), .i_da_data(i_da_data), .o_iac_hit(iac_hit),
    .o_dac_hit(dac_hit), .o_cnt_event(cnt_event),
    .o_ext_debug_mode(ext_mode));
  drc_dbg_model drc_dbg_model_i (.i_mclk(i_mclk), .i_go(go),
    .i_spr(go_spr), .i_mask(go_mask), .i_val(go_val), .i_rdata(dp_rdata),
    .o_dp_wr(dp_wr), .o_dp_rd(dp_rd), .o_dp_spr(dp_spr),
    .o_dp_wdata(dp_wdata));

  always #12.5 i_mclk = ~i_mclk;
  always @(posedge i_mclk) cyc_n <= cyc_n + 1;

  task automatic tally_and_finish();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk_data(input string nm, input logic [63:0] e,
                          input logic [63:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_data
  task automatic chk_hits(input string nm, input logic [9:0] e,
                          input logic [9:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_hits
  task automatic note(input int k, input int d, input logic [63:0] e);
    q.push_back('{k, cyc_n + d, e});
  endtask : note

  // notes are pushed in due order, so only the head needs looking at
  always @(negedge i_mclk) begin
    while (q.size() > 0 && q[0].due <= cyc_n) begin
      n = q.pop_front();
      case (n.kind)
        0: chk_data("sw read data", n.exp, sw_rdata);
        1: chk_data("dp read data", n.exp, dp_rdata);
        2: chk_hits("compare hits", n.exp[9:0], {dac_hit, iac_hit});
        3: chk_hits("count event", n.exp[9:0], {8'h0, cnt_event});
        default: chk_data("ext mode", n.exp, {63'h0, ext_mode});
      endcase
    end
  end

  task automatic sw_wr(input drc_pkg::drc_spr_t s, input logic [63:0] d);
    @(posedge i_mclk);
    i_sw_wr <= 1'b1;
    i_sw_spr <= s;
    i_sw_wdata <= d;
    @(posedge i_mclk);
    i_sw_wr <= 1'b0;
    i_sw_wdata <= ~d;
  endtask : sw_wr
  task automatic sw_rd(input drc_pkg::drc_spr_t s, input logic [63:0] e);
    @(posedge i_mclk);
    i_sw_rd <= 1'b1;
    i_sw_spr <= s;
    note(0, 2, e);
    @(posedge i_mclk);
    i_sw_rd <= 1'b0;
  endtask : sw_rd
  task automatic dp_rmw(input drc_pkg::drc_spr_t s, input logic [63:0] m,
                        input logic [63:0] v, input logic c,
                        input logic [63:0] e);
    @(posedge i_mclk);
    go <= 1'b1;
    go_spr <= s;
    go_mask <= m;
    go_val <= v;
    if (c) note(1, 3, e);
    @(posedge i_mclk);
    go <= 1'b0;
    repeat (3) @(posedge i_mclk);
  endtask : dp_rmw
  task automatic fetch(input logic [31:0] a, input logic variable_length_encoding,
                       input logic [7:0] h, input logic [1:0] ev);
    @(posedge i_mclk);
    i_if_vld <= 1'b1;
    i_da_vld <= 1'b0;
    i_if_addr <= a;
    i_if_vle <= variable_length_encoding;
    note(2, 2, {56'h0, h});
    note(3, 2, {62'h0, ev});
  endtask : fetch
  task automatic dacc(input logic [31:0] a, input logic [7:0] l,
                      input logic [63:0] d, input logic s,
                      input logic [1:0] h);
    @(posedge i_mclk);
    i_if_vld <= 1'b0;
    i_da_vld <= 1'b1;
    i_da_addr <= a;
    i_da_lanes <= l;
    i_da_data <= d;
    i_da_second <= s;
    i_da_store <= 1'($random(seed));
    note(2, 2, {h, 8'h0});
  endtask : dacc
  task automatic idle();
    @(posedge i_mclk);
    i_if_vld <= 1'b0;
    i_da_vld <= 1'b0;
    repeat (3) @(posedge i_mclk);
  endtask : idle

  initial begin
    repeat (4000) @(posedge i_mclk);
    fails++;
    tally_and_finish();
  end

  initial begin
    r64 = {$random(seed), $random(seed)};
    repeat (6) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    sw_rd(`DRC_SPR_CTRL, 64'h0);
    sw_rd(10'h3ff, 64'h0);
    sw_wr(`DRC_SPR_DATA_VALUE_COMPARE_FIRST, r64);
    sw_rd(`DRC_SPR_DATA_VALUE_COMPARE_FIRST, r64);
    sw_wr(`DRC_SPR_CNT, {32'h0, r64[31:0]});
    sw_rd(`DRC_SPR_CNT, {32'h0, r64[31:0]});
    sw_wr(`DRC_SPR_CTRL, 64'hc000_0000);
    sw_rd(`DRC_SPR_CTRL, 64'h4000_0000);
    dp_rmw(`DRC_SPR_CTRL, 64'h8000_0000, 64'h8000_0000, 1'b1,
           64'h4000_0000);
    // give the new mode a quiet cycle before software relies on it
    note(4, 2, 64'h1);
    sw_wr(`DRC_SPR_IAC0, 64'h1234);
    dp_rmw(`DRC_SPR_IAC0, 64'h0, 64'h0, 1'b1, 64'h0);
    dp_rmw(`DRC_SPR_OWN, 64'h2, 64'h2, 1'b0, 64'h0);
    sw_rd(`DRC_SPR_OWN, 64'h2);
    sw_wr(`DRC_SPR_IAC0, {32'h0, r64[63:34], 2'h0});
    sw_rd(`DRC_SPR_IAC0, {32'h0, r64[63:34], 2'h0});
    dp_rmw(`DRC_SPR_IAC0, '1, 64'h1000_0000, 1'b0, 64'h0);
    fetch(32'h1000_0003, 1'b0, 8'h01, 2'h0);
    fetch(32'h1000_0001, 1'b1, 8'h01, 2'h0);
    fetch(32'h1000_0002, 1'b1, 8'h00, 2'h0);
    fetch(32'h1000_0004, 1'b0, 8'h00, 2'h0);
    idle();
    dp_rmw(`DRC_SPR_IAC0, '1, 64'h2000_0000, 1'b0, 64'h0);
    dp_rmw(`DRC_SPR_IAC0 + 10'h1, '1, 64'h2000_0000, 1'b0, 64'h0);
    fetch(32'h2000_0000, 1'b0, 8'h03, 2'h0);
    idle();
    dp_rmw(`DRC_SPR_CNT, '1, 64'h0002_0000, 1'b0, 64'h0);
    dp_rmw(`DRC_SPR_CFG, '1, 64'h0500_0001, 1'b0, 64'h0);
    fetch(32'h2000_0000, 1'b0, 8'h01, 2'h0);
    fetch(32'h2000_0000, 1'b0, 8'h01, 2'h2);
    fetch(32'h2000_0000, 1'b0, 8'h01, 2'h0);
    idle();
    dp_rmw(`DRC_SPR_CNT, 64'h0, 64'h0, 1'b1, 64'h0);
    // chained: lower borrows from upper, 0x1_0001 steps to 0xffff
    dp_rmw(`DRC_SPR_CNT, '1, 64'h0001_0001, 1'b0, 64'h0);
    dp_rmw(`DRC_SPR_CFG, '1, 64'h0400_0080, 1'b0, 64'h0);
    fetch(32'h2000_0000, 1'b0, 8'h03, 2'h0);
    fetch(32'h2000_0000, 1'b0, 8'h03, 2'h0);
    idle();
    dp_rmw(`DRC_SPR_CNT, 64'h0, 64'h0, 1'b1, 64'h0000_ffff);
    dp_rmw(`DRC_SPR_CNT, '1, 64'h1, 1'b0, 64'h0);
    dp_rmw(`DRC_SPR_CFG, '1, 64'h0400_0000, 1'b0, 64'h0);
    fetch(32'h2000_0000, 1'b0, 8'h03, 2'h1);
    fetch(32'h2000_0000, 1'b0, 8'h03, 2'h0);
    idle();
    dp_rmw(`DRC_SPR_DAC0, '1, 64'h3000_0008, 1'b0, 64'h0);
    dp_rmw(`DRC_SPR_DATA_VALUE_COMPARE_FIRST, '1, 64'h1122_3344_5566_7788, 1'b0, 64'h0);
    dp_rmw(`DRC_SPR_CFG, '1, 64'h0000_0120, 1'b0, 64'h0);
    dacc(32'h3000_0008, 8'h01, 64'h11ff_0000_0000_0000, 1'b0, 2'h1);
    dacc(32'h3000_0008, 8'h01, 64'h12ff_0000_0000_0000, 1'b0, 2'h0);
    dacc(32'h3000_0008, 8'h02, 64'h1200_0000_0000_0000, 1'b0, 2'h1);
    dacc(32'h3000_0008, 8'h01, 64'h1100_0000_0000_0000, 1'b1, 2'h0);
    idle();
    dp_rmw(`DRC_SPR_CFG, '1, 64'h0000_8020, 1'b0, 64'h0);
    dacc(32'h3000_0008, 8'h80, 64'h0000_0000_0000_0088, 1'b0, 2'h1);
    idle();
    dp_rmw(`DRC_SPR_DAC0 + 10'h1, '1, 64'h3000_0008, 1'b0, 64'h0);
    dp_rmw(`DRC_SPR_CFG, '1, 64'h0000_0010, 1'b0, 64'h0);
    dacc(32'h3000_0008, 8'hff, 64'h0, 1'b0, 2'h1);
    idle();
    // enable first data compare events: bit 19 load, bit 18 store
    dp_rmw(`DRC_SPR_CTRL, 64'h000c_0000, 64'h000c_0000, 1'b0, 64'h0);
    dacc(32'h3000_0008, 8'hff, 64'h0, 1'b0, 2'h1);
    idle();
    sw_rd(`DRC_SPR_STAT, i_da_store ? 64'h4_0000 : 64'h8_0000);
    sw_wr(`DRC_SPR_STAT, 64'hffff_ffff);
    sw_rd(`DRC_SPR_STAT, 64'h0);
    // a second reset must leave the value compare contents alone
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    note(4, 1, 64'h0);
    dp_rmw(`DRC_SPR_DATA_VALUE_COMPARE_FIRST, 64'h0, 64'h0, 1'b1,
           64'h1122_3344_5566_7788);
    sw_rd(`DRC_SPR_CTRL, 64'h0);
    repeat (4) @(posedge i_mclk);
    tally_and_finish();
  end
endmodule : test_drc_debug_regs
